/* hw/gate_driver_spi_mode_control.v */
// Purpose: Serial register interface, sleep/wake sequencing and fault reset.
// Assumes: Pins are asynchronous; clk is 250 MHz.
// Notes:   Fault sources are raw levels from the analog monitors.
//
// Behaviour
// - Enable low puts the device into sleep, disabling drivers, pump, regulator, serial.
// - Sleep entry waits the sleep delay after enable falls.
// - Enable high wakes the device with no command.
// - Fault indicator held low while regulators settle after enable changes.
// - Enable high and supply good means operating mode, all supplies active.
// - Latched fault shuts down partially until cleared with fault gone.
// - Enable low inside reset window is a fault reset; longer starts sleep.
// - Enable reset pulse clears faults only, keeps settings and regulators.
// - Slave accepts 16-bit words: 5 command bits then 11 data bits.
// - Output word: 5 don't-care bits then 11 register bits.
// - Chip select high ignores clock and data, output tri-stated.
// - Input sampled on falling clock, output changed on rising clock.
// - Words shift most significant bit first.
// - Frame not exactly 16 clocks flags error and is dropped.
// - Answer carries the addressed register, old value on writes.
// - Bit 15 direction, bits 14-11 address, bits 10-0 data.
// - Addresses 0 and 1 are read-only status.
// - Reserved bits reset to zero.
// - Status bit 10 is OR of all flags and mirrors fault indicator.
// - Writing clear-latched-faults clears flags and self-resets.
// - Lock key 110 blocks writes except key and low control bits; 011 unlocks.
`timescale 1ns/1ps
`default_nettype none
`include "gate_driver_defines.vh"
module gate_driver_spi_mode_control #(
    parameter SLEEP_CYC  = (`SLEEP_NS) / (`CLK_NS),
    parameter WAKE_CYC   = (`WAKE_NS) / (`CLK_NS),
    parameter RST_MIN    = ((`RST_MIN_NS) + (`CLK_NS) - 1) / (`CLK_NS),
    parameter RST_MAX    = (`RST_MAX_NS) / (`CLK_NS),
    parameter TW         = 20
) (
    // Clock and reset.
    input  wire                  clk,
    input  wire                  rst,
    // Enable and supply pins.
    input  wire                  enablePin,
    input  wire                  supplyUvlo,
    // Serial pins.
    input  wire                  sclk,
    input  wire                  chip_select_n,
    input  wire                  mosi,
    output wire                  misoO,
    output wire                  misoOe,
    // Fault monitor levels, one per status bit except primary bit 10.
    input  wire [`DATA_BITS-2:0] faultPriIn,
    input  wire [`DATA_BITS-1:0] faultSecIn,
    // Power and drive controls.
    output reg                   regulatorsOn,
    output reg                   gateDriveEn,
    output wire                  fault_indicator_n,
    output reg                   frameErr,
    output wire [`DATA_BITS-1:0] driveCtl,
    output wire [`DATA_BITS-1:0] hsDrive,
    output wire [`DATA_BITS-1:0] lsDrive,
    output wire [`DATA_BITS-1:0] ocpCtl,
    output wire [`DATA_BITS-1:0] senseCtl
);
    // ------------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------------
    wire [5:0] pinsS;
    pin_sync #(.W(6)) u_sync (
        .clk   (clk),
        .rst   (rst),
        .async ({enablePin, supplyUvlo, sclk, chip_select_n, mosi, 1'b0}),
        .sync  (pinsS)
    );
    wire enS   = pinsS[5];
    wire uvloS = pinsS[4];
    wire csnS  = pinsS[2] | ~enS;
    wire sclkS = pinsS[3];
    wire mosiS = pinsS[1];

    // Fault monitors run free of clk, so they cross two stages as well.
    wire [`DATA_BITS-2:0] faultPriS;
    wire [`DATA_BITS-1:0] faultSecS;
    pin_sync #(.W(2*`DATA_BITS-1)) u_fsync (
        .clk   (clk),
        .rst   (rst),
        .async ({faultPriIn, faultSecIn}),
        .sync  ({faultPriS, faultSecS})
    );

    // ------------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------------
    localparam [3:0] ST_SLEEP = 4'b0001;
    localparam [3:0] ST_WAKE  = 4'b0010;
    localparam [3:0] ST_RUN   = 4'b0100;
    localparam [3:0] ST_LOW   = 4'b1000;

    reg [3:0]    state_r;
    reg [3:0]    state_nxt;
    reg [TW-1:0] tmr_r;
    reg [TW-1:0] tmr_nxt;
    reg          enPulse_r;
    reg          enPulse_nxt;

    always @* begin
        state_nxt   = state_r;
        tmr_nxt     = tmr_r + 1'b1;
        enPulse_nxt = 1'b0;
        case (state_r)
            ST_SLEEP: begin
                tmr_nxt = {TW{1'b0}};
                if (enS) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (!enS) begin
                    state_nxt = ST_LOW;
                    tmr_nxt   = {TW{1'b0}};
                end else if (tmr_r >= WAKE_CYC - 1) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                tmr_nxt = {TW{1'b0}};
                if (!enS) begin
                    state_nxt = ST_LOW;
                end
            end
            ST_LOW: begin
                if (enS) begin
                    // A short low is a reset pulse and leaves power untouched.
                    if (tmr_r >= RST_MIN - 1 && tmr_r < RST_MAX) begin
                        enPulse_nxt = 1'b1;
                    end
                    state_nxt = (tmr_r < RST_MAX) ? ST_RUN : ST_WAKE;
                    tmr_nxt   = {TW{1'b0}};
                end else if (tmr_r >= SLEEP_CYC - 1) begin
                    state_nxt = ST_SLEEP;
                end
            end
            default: begin
                state_nxt = ST_SLEEP;
                tmr_nxt   = {TW{1'b0}};
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            state_r   <= ST_SLEEP;
            tmr_r     <= {TW{1'b0}};
            enPulse_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            tmr_r     <= tmr_nxt;
            enPulse_r <= enPulse_nxt;
        end
    end

    // Regulators settle while waking and while falling into sleep past the window.
    wire settling = (state_r == ST_WAKE) ||
                    (state_r == ST_LOW && tmr_r >= RST_MAX);
    wire active   = (state_r == ST_RUN) && !uvloS;

    // ------------------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------------------
    wire [`ADDR_BITS-1:0]  addrNow;
    wire                   frameDone;
    wire                   frameBad;
    wire [`FRAME_BITS-1:0] word;
    reg  [`DATA_BITS-1:0]  answer;

    serial_frame u_frame (
        .clk        (clk),
        .rst        (rst),
        .sclkS      (sclkS),
        .csnS       (csnS),
        .mosiS      (mosiS),
        .active     (active),
        .answer     (answer),
        .addrNow    (addrNow),
        .frameDone  (frameDone),
        .frameError (frameBad),
        .word       (word),
        .misoO      (misoO),
        .misoOe     (misoOe)
    );

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg  [`DATA_BITS-1:0] regs_r [2:7];
    reg  [`DATA_BITS-2:0] latPri_r;
    reg  [`DATA_BITS-1:0] latSec_r;

    wire                  isWrite = frameDone && !word[`DIR_POS];
    wire [`ADDR_BITS-1:0] wAddr   = word[`ADDR_HI:`ADDR_LO];
    wire [`DATA_BITS-1:0] wData   = word[`DATA_HI:`DATA_LO];
    wire                  locked  = (regs_r[3][`LOCK_HI:`LOCK_LO] == `LOCK_ON);
    wire                  faultAny = |{latPri_r, latSec_r};
    wire                  clrReq  = (isWrite && wAddr == `ADDR_DRIVE_CTL &&
                                     wData[`CLEAR_LATCHED_FAULTS_POS]) || enPulse_r;
    wire [`DATA_BITS-1:0] statPri = {faultAny, latPri_r};

    function [`DATA_BITS-1:0] rstVal;
        input [2:0] idx;
        begin
            case (idx)
                3'h2:    rstVal = `RST_DRIVE_CTL;
                3'h3:    rstVal = `RST_HS_DRIVE;
                3'h4:    rstVal = `RST_LS_DRIVE;
                3'h5:    rstVal = `RST_OCP_CTL;
                3'h6:    rstVal = `RST_SENSE_CTL;
                default: rstVal = `RST_RSVD;
            endcase
        end
    endfunction

    always @* begin
        case (addrNow)
            `ADDR_FAULT_PRI: answer = statPri;
            `ADDR_FAULT_SEC: answer = latSec_r;
            `ADDR_DRIVE_CTL: answer = regs_r[2];
            `ADDR_HS_DRIVE:  answer = regs_r[3];
            `ADDR_LS_DRIVE:  answer = regs_r[4];
            `ADDR_OCP_CTL:   answer = regs_r[5];
            `ADDR_SENSE_CTL: answer = regs_r[6];
            `ADDR_RSVD:      answer = regs_r[7];
            default:         answer = {`DATA_BITS{1'b0}};
        endcase
    end

    integer i;
    always @(posedge clk) begin
        if (rst) begin
            for (i = 2; i <= 7; i = i + 1) begin
                regs_r[i] <= rstVal(i[2:0]);
            end
            latPri_r <= {(`DATA_BITS-1){1'b0}};
            latSec_r <= {`DATA_BITS{1'b0}};
            frameErr <= 1'b0;
        end else begin
            frameErr <= frameBad;

            // Set wins over clear so no event slips through a clear.
            latPri_r <= (clrReq ? {(`DATA_BITS-1){1'b0}} : latPri_r) | faultPriS;
            latSec_r <= (clrReq ? {`DATA_BITS{1'b0}} : latSec_r) | faultSecS;

            // The clear bit never stays set.
            regs_r[2][`CLEAR_LATCHED_FAULTS_POS] <= 1'b0;

            if (isWrite && wAddr >= `ADDR_DRIVE_CTL && wAddr <= `ADDR_RSVD) begin
                if (wAddr == `ADDR_HS_DRIVE) begin
                    // Other key codes leave the lock field as it stands, so a
                    // stray write cannot half-open the lock.
                    if (!locked && wData[`LOCK_HI:`LOCK_LO] == `LOCK_ON) begin
                        regs_r[3] <= wData;
                    end else if (locked && wData[`LOCK_HI:`LOCK_LO] == `LOCK_OFF) begin
                        regs_r[3][`LOCK_HI:`LOCK_LO] <= `LOCK_OFF;
                    end else if (!locked) begin
                        regs_r[3][`LOCK_LO-1:0] <= wData[`LOCK_LO-1:0];
                    end
                end else if (wAddr == `ADDR_DRIVE_CTL) begin
                    regs_r[2][2:1] <= wData[2:1];
                    if (!locked) begin
                        regs_r[2][9:3] <= wData[9:3];
                    end
                end else if (!locked) begin
                    regs_r[wAddr[2:0]] <= wData;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign fault_indicator_n = ~(faultAny || settling);
    assign driveCtl = regs_r[2];
    assign hsDrive  = regs_r[3];
    assign lsDrive  = regs_r[4];
    assign ocpCtl   = regs_r[5];
    assign senseCtl = regs_r[6];

    always @(posedge clk) begin
        if (rst) begin
            regulatorsOn <= 1'b0;
            gateDriveEn  <= 1'b0;
        end else begin
            regulatorsOn <= (state_nxt != ST_SLEEP);
            gateDriveEn  <= (state_nxt == ST_RUN) && !uvloS && !faultAny;
        end
    end
endmodule // gate_driver_spi_mode_control
`default_nettype wire

/* hw/pin_sync.v */
// Purpose: Two flip-flop synchroniser for a bundle of pin levels.
// Assumes: Inputs are asynchronous to clk.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter W = 1
) (
    // Clock and reset.
    input  wire         clk,
    input  wire         rst,
    // Levels.
    input  wire [W-1:0] async,
    output reg  [W-1:0] sync
);
    reg [W-1:0] meta_r;

    always @(posedge clk) begin
        if (rst) begin
            meta_r <= {W{1'b0}};
            sync   <= {W{1'b0}};
        end else begin
            meta_r <= async;
            sync   <= meta_r;
        end
    end
endmodule // pin_sync
`default_nettype wire

/* hw/serial_frame.v */
// Purpose: Serial slave shifter: collects one frame, shifts the answer out.
// Assumes: Pins already synchronised to clk.
// Notes:   Serial clock edges are found by sampling with clk.
`timescale 1ns/1ps
`default_nettype none
`include "gate_driver_defines.vh"
module serial_frame (
    // Clock and reset.
    input  wire                     clk,
    input  wire                     rst,
    // Synchronised pins.
    input  wire                     sclkS,
    input  wire                     csnS,
    input  wire                     mosiS,
    input  wire                     active,
    // Answer word loaded after the fifth bit.
    input  wire [`DATA_BITS-1:0]    answer,
    output wire [`ADDR_BITS-1:0]    addrNow,
    // Frame results.
    output reg                      frameDone,
    output reg                      frameError,
    output reg  [`FRAME_BITS-1:0]   word,
    // Output pin.
    output reg                      misoO,
    output wire                     misoOe
);
    reg                     sclkD_r;
    reg                     csnD_r;
    reg [`CNT_BITS-1:0]     cnt_r;
    reg [`FRAME_BITS-1:0]   shIn_r;
    reg [`DATA_BITS-1:0]    shOut_r;

    wire sel  = ~csnS & active;
    wire fall = sel & sclkD_r & ~sclkS;
    wire rise = sel & ~sclkD_r & sclkS;
    wire endF = ~csnD_r & csnS;

    assign addrNow = {shIn_r[`ADDR_BITS-2:0], mosiS};
    assign misoOe  = sel;

    always @(posedge clk) begin
        if (rst) begin
            sclkD_r    <= 1'b0;
            csnD_r     <= 1'b1;
            cnt_r      <= {`CNT_BITS{1'b0}};
            shIn_r     <= {`FRAME_BITS{1'b0}};
            shOut_r    <= {`DATA_BITS{1'b0}};
            frameDone  <= 1'b0;
            frameError <= 1'b0;
            word       <= {`FRAME_BITS{1'b0}};
            misoO      <= 1'b0;
        end else begin
            sclkD_r    <= sclkS;
            csnD_r     <= csnS;
            frameDone  <= 1'b0;
            frameError <= 1'b0;
            if (csnS) begin
                cnt_r <= {`CNT_BITS{1'b0}};
            end else if (fall) begin
                shIn_r <= {shIn_r[`FRAME_BITS-2:0], mosiS};
                if (cnt_r != 5'h1f) begin
                    cnt_r <= cnt_r + 5'h01;
                end
                if (cnt_r == 5'h04) begin
                    shOut_r <= answer;
                end
            end
            if (rise && cnt_r >= 5'h05) begin
                misoO   <= shOut_r[`DATA_BITS-1];
                shOut_r <= {shOut_r[`DATA_BITS-2:0], 1'b0};
            end
            if (endF && active) begin
                if (cnt_r == 5'h10) begin
                    frameDone <= 1'b1;
                    word      <= shIn_r;
                end else if (cnt_r != 5'h00) begin
                    frameError <= 1'b1;
                end
            end
        end
    end
endmodule // serial_frame
`default_nettype wire

/* include/gate_driver_defines.vh */
// Purpose: Shared constants for the gate driver serial mode control block.
// Assumes: Included by bare name from the design files.
// Notes:   Timing figures are in nanoseconds; cycle counts derive from CLK_NS.
`ifndef GATE_DRIVER_DEFINES_VH
`define GATE_DRIVER_DEFINES_VH

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define FRAME_BITS      16
`define DATA_BITS       11
`define ADDR_BITS       4
`define CNT_BITS        5
`define DIR_POS         15
`define ADDR_HI         14
`define ADDR_LO         11
`define DATA_HI         10
`define DATA_LO         0

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_FAULT_PRI  4'h0
`define ADDR_FAULT_SEC  4'h1
`define ADDR_DRIVE_CTL  4'h2
`define ADDR_HS_DRIVE   4'h3
`define ADDR_LS_DRIVE   4'h4
`define ADDR_OCP_CTL    4'h5
`define ADDR_SENSE_CTL  4'h6
`define ADDR_RSVD       4'h7

// ----------------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------------
`define RST_DRIVE_CTL   11'h000
`define RST_HS_DRIVE    11'h3ff
`define RST_LS_DRIVE    11'h7ff
`define RST_OCP_CTL     11'h159
`define RST_SENSE_CTL   11'h283
`define RST_RSVD        11'h000
`define CLEAR_LATCHED_FAULTS_POS     0
`define RSVD_DRV_POS    10
`define LOCK_HI         10
`define LOCK_LO         8
`define LOCK_ON         3'h6
`define LOCK_OFF        3'h3
`define UNLOCKED_MASK   11'h007
`define FAULT_SUM_POS   10

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_NS          4
`define SLEEP_NS        1000000
`define WAKE_NS         1000000
`define RST_MIN_NS      5000
`define RST_MAX_NS      40000

`endif

/* tb/gate_driver_spi_mode_control_sva.sv */
// Purpose: Port-level assertions for the serial mode control block.
// Assumes: Pins are sampled by clk; sleep count comes in as a parameter.
// Notes:   Bound to the block's top module at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
`include "gate_driver_defines.vh"
module gate_driver_spi_mode_control_sva #(
    parameter SLEEP_CYC = 250000
) (
    // Clock, reset and pins.
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  enablePin,
    input wire logic                  supplyUvlo,
    input wire logic                  sclk,
    input wire logic                  chip_select_n,
    input wire logic                  misoO,
    input wire logic                  misoOe,
    // Status and registers.
    input wire logic                  regulatorsOn,
    input wire logic                  gateDriveEn,
    input wire logic                  fault_indicator_n,
    input wire logic                  frameErr,
    input wire logic [`DATA_BITS-1:0] driveCtl,
    input wire logic [`DATA_BITS-1:0] hsDrive,
    input wire logic [`DATA_BITS-1:0] lsDrive,
    input wire logic [`DATA_BITS-1:0] ocpCtl,
    input wire logic [`DATA_BITS-1:0] senseCtl
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Enable low time, saturating so a long sleep never wraps.
    // ------------------------------------------------------------------
    logic [19:0] lowCnt_r;
    always_ff @(posedge clk) begin
        if (rst || enablePin) lowCnt_r <= '0;
        else if (lowCnt_r != 20'hfffff) lowCnt_r <= lowCnt_r + 20'h1;
    end

    sequence s_wake_start;
        $rose(enablePin) && !regulatorsOn;
    endsequence
    sequence s_settle_flag;
        ##[1:8] !fault_indicator_n;
    endsequence

    property p_cs_idle; chip_select_n [*6] |-> !misoOe; endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("data out driven while deselected");
    property p_sleep_off; lowCnt_r > SLEEP_CYC + 8 |-> !regulatorsOn; endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("still awake after sleep delay");
    property p_sleep_delay;
        regulatorsOn && lowCnt_r != 0 && lowCnt_r < SLEEP_CYC |=> regulatorsOn;
    endproperty
    a_sleep_delay: assert property (p_sleep_delay) else $error("sleep entered early");
    property p_sleep_quiet; !regulatorsOn [*2] |-> !gateDriveEn && !misoOe; endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("active while asleep");
    property p_supply_undervoltage_lockout_stop; supplyUvlo [*4] |-> !gateDriveEn; endproperty
    a_supply_undervoltage_lockout_stop: assert property (p_supply_undervoltage_lockout_stop) else $error("drive on under low supply");
    property p_fault_stop; !fault_indicator_n [*2] |-> !gateDriveEn; endproperty
    a_fault_stop: assert property (p_fault_stop) else $error("drive on with fault");
    property p_err_pulse; frameErr |-> chip_select_n ##1 !frameErr; endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("frame error pulse wrong");
    property p_commit_idle;
        !$stable({driveCtl, hsDrive, lsDrive, ocpCtl, senseCtl}) |-> chip_select_n;
    endproperty
    a_commit_idle: assert property (p_commit_idle) else $error("register changed in frame");
    property p_miso_rise; misoOe && $past(misoOe) && $changed(misoO) |-> sclk; endproperty
    a_miso_rise: assert property (p_miso_rise) else $error("data out moved off rise");
    property p_wake_flag; s_wake_start |-> s_settle_flag; endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("fault pin not held on wake");
endmodule // gate_driver_spi_mode_control_sva

bind gate_driver_spi_mode_control gate_driver_spi_mode_control_sva #(.SLEEP_CYC(SLEEP_CYC)) u_sva (
    .clk(clk), .rst(rst), .enablePin(enablePin), .supplyUvlo(supplyUvlo), .sclk(sclk),
    .chip_select_n(chip_select_n), .misoO(misoO), .misoOe(misoOe),
    .regulatorsOn(regulatorsOn), .gateDriveEn(gateDriveEn),
    .fault_indicator_n(fault_indicator_n), .frameErr(frameErr), .driveCtl(driveCtl),
    .hsDrive(hsDrive), .lsDrive(lsDrive), .ocpCtl(ocpCtl), .senseCtl(senseCtl));
`default_nettype wire

/* tb/spi_master_model.sv */
// Purpose: Master controller model that drives the serial pins of the block.
// Assumes: Called on a falling clk edge; the serial clock half period is 24 ns.
// Notes:   The serial clock stands low between frames and the data line toggles there.
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    // Serial pins toward the device.
    output logic     sclk,
    output logic     chip_select_n,
    output logic     mosi,
    input wire logic miso
);
    localparam int HALF_NS = 24;

    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        mosi = 1'b0;
    end

    // Sends the low nBits of tx; fewer or more than 16 makes a bad frame on purpose.
    task automatic xfer(input logic [16:0] tx, input int nBits, output logic [15:0] rx);
        rx = '0;
        chip_select_n = 1'b0;
        for (int i = nBits - 1; i >= 0; i--) begin
            #HALF_NS sclk = 1'b1;
            mosi = tx[i];
            #HALF_NS sclk = 1'b0;
            rx = {rx[14:0], miso};
        end
        #HALF_NS chip_select_n = 1'b1;
        mosi = ~mosi;
        #400;
    endtask
endmodule // spi_master_model
`default_nettype wire

/* tb/tb_gate_driver_spi_mode_control.sv */
// Purpose: Self-checking bench for the serial mode control block.
// Assumes: Sleep, wake and reset-pulse counts shortened to 50, 50, 5 and 40.
// Notes:   Short counts keep the run brief; the logic is the same at full length.
`timescale 1ns/1ps
`default_nettype none
`include "gate_driver_defines.vh"
module tb_gate_driver_spi_mode_control;
    localparam int WAKE = 50;
    localparam logic [10:0] RST_TAB [0:6] = '{`RST_DRIVE_CTL, `RST_HS_DRIVE, `RST_LS_DRIVE,
        `RST_OCP_CTL, `RST_SENSE_CTL, `RST_RSVD, 11'h000};
    logic        clk, rst, enablePin, supplyUvlo, sclk, chip_select_n, mosi, misoO, misoOe;
    logic        regulatorsOn, gateDriveEn, fault_indicator_n, frameErr;
    logic [9:0]  faultPriIn;
    logic [10:0] faultSecIn, driveCtl, hsDrive, lsDrive, ocpCtl, senseCtl, v;
    logic [15:0] rx16;
    wire         misoLine;
    int          errors, checks_done, cycles, errPulses;

    assign misoLine = misoOe ? misoO : 1'bz;

    gate_driver_spi_mode_control #(.SLEEP_CYC(50), .WAKE_CYC(WAKE), .RST_MIN(5), .RST_MAX(40)) dut (
        .clk(clk), .rst(rst), .enablePin(enablePin), .supplyUvlo(supplyUvlo), .sclk(sclk),
        .chip_select_n(chip_select_n), .mosi(mosi), .misoO(misoO), .misoOe(misoOe),
        .faultPriIn(faultPriIn), .faultSecIn(faultSecIn), .regulatorsOn(regulatorsOn),
        .gateDriveEn(gateDriveEn), .fault_indicator_n(fault_indicator_n), .frameErr(frameErr),
        .driveCtl(driveCtl), .hsDrive(hsDrive), .lsDrive(lsDrive), .ocpCtl(ocpCtl),
        .senseCtl(senseCtl));
    spi_master_model m (.sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi), .miso(misoLine));

    initial clk = 1'b0;
    always #2 clk = ~clk;

    // ------------------------------------------------------------------
    // Watchdog and frame error pulse counter.
    // ------------------------------------------------------------------
    always @(negedge clk) begin
        cycles++;
        if (frameErr === 1'b1) errPulses++;
        if (cycles == 40000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic rd, input logic [3:0] a, input logic [10:0] d);
        m.xfer({1'b0, rd, a, d}, 16, rx16);
        v = rx16[10:0];
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        enablePin = 1'b0;
        supplyUvlo = 1'b0;
        faultPriIn = '0;
        faultSecIn = '0;
        wait_clk(10);
        rst = 1'b0;
        wait_clk(2);
        enablePin = 1'b1;
        wait_clk(10);
        check(11'(fault_indicator_n), 11'h0);
        wait_clk(WAKE + 4);
        check(11'({regulatorsOn, gateDriveEn, fault_indicator_n}), 11'h7);
        for (int i = 0; i < 7; i++) begin
            acc(1'b1, 4'(i + 2), 11'h000);
            check(v, RST_TAB[i]);
        end
        check(ocpCtl, `RST_OCP_CTL);
        check(senseCtl, `RST_SENSE_CTL);
        acc(1'b0, `ADDR_HS_DRIVE, 11'h2a5);
        check(v, `RST_HS_DRIVE);
        check(hsDrive, 11'h3a5);
        acc(1'b1, `ADDR_HS_DRIVE, 11'h000);
        check(v, 11'h3a5);
        for (int i = 0; i < 2; i++) begin
            acc(1'b0, 4'(i), 11'h3ff);
            acc(1'b1, 4'(i), 11'h000);
            check(v, 11'h000);
        end
        // Bad lengths 15 and 17 give one more error pulse each.
        for (int n = 15; n <= 17; n += 2) begin
            m.xfer(17'h02123, n, rx16);
            check(11'(errPulses), 11'(n / 2 - 6));
            check(lsDrive, `RST_LS_DRIVE);
        end
        acc(1'b0, `ADDR_HS_DRIVE, {`LOCK_ON, 8'h00});
        acc(1'b0, `ADDR_LS_DRIVE, 11'h055);
        check(lsDrive, `RST_LS_DRIVE);
        acc(1'b0, `ADDR_DRIVE_CTL, 11'h7fe);
        check(driveCtl, 11'h006);
        acc(1'b0, `ADDR_HS_DRIVE, {`LOCK_OFF, 8'h00});
        acc(1'b0, `ADDR_LS_DRIVE, 11'h055);
        check(lsDrive, 11'h055);
        faultPriIn = 10'h008;
        wait_clk(8);
        check(11'({fault_indicator_n, gateDriveEn}), 11'h0);
        faultPriIn = 10'h000;
        faultSecIn = 11'h040;
        acc(1'b1, `ADDR_FAULT_PRI, 11'h000);
        check(v, 11'h408);
        acc(1'b1, `ADDR_FAULT_SEC, 11'h000);
        check(v, 11'h040);
        faultSecIn = 11'h000;
        check(11'(fault_indicator_n), 11'h0);
        acc(1'b0, `ADDR_DRIVE_CTL, 11'h007);
        check(11'({fault_indicator_n, gateDriveEn}), 11'h3);
        check(driveCtl, 11'h006);
        acc(1'b1, `ADDR_FAULT_PRI, 11'h000);
        check(v, 11'h000);
        faultPriIn = 10'h200;
        wait_clk(8);
        faultPriIn = 10'h000;
        enablePin = 1'b0;
        wait_clk(20);
        enablePin = 1'b1;
        wait_clk(20);
        check(11'({fault_indicator_n, regulatorsOn}), 11'h3);
        check(driveCtl, 11'h006);
        enablePin = 1'b0;
        wait_clk(30);
        check(11'(regulatorsOn), 11'h1);
        wait_clk(40);
        check(11'({regulatorsOn, gateDriveEn}), 11'h0);
        acc(1'b1, `ADDR_HS_DRIVE, 11'h000);
        check(11'(errPulses), 11'h2);
        enablePin = 1'b1;
        wait_clk(WAKE + 8);
        check(11'({regulatorsOn, fault_indicator_n}), 11'h3);
        supplyUvlo = 1'b1;
        wait_clk(8);
        check(11'(gateDriveEn), 11'h0);
        end_of_test();
    end
endmodule // tb_gate_driver_spi_mode_control
`default_nettype wire
